// ### design/ucs_pkg.sv
`default_nettype none
package ucs_pkg;

   // register map, byte addresses on the local register port
   localparam logic [3:0] UCS_OFS_SYS_CONFIG = 4'h0;
   localparam logic [3:0] UCS_OFS_WIN0 = 4'h4;
   localparam logic [3:0] UCS_OFS_WIN1 = 4'h8;

   // system_config_register: bits 7:6 reserved, cache_mode_field in 2:1
   localparam logic [7:0] UCS_SYS_CONFIG_RST = 8'h01;
   localparam logic [7:0] UCS_SYS_CONFIG_MASK = 8'h3F;
   localparam int UCS_MODE_LSB = 1;
   localparam logic [1:0] UCS_MODE_OFF = 2'h0;
   localparam logic [1:0] UCS_MODE_HALF = 2'h1;
   localparam logic [1:0] UCS_MODE_RSVD = 2'h2;
   localparam logic [1:0] UCS_MODE_FULL = 2'h3;

   // uncached_window_bounds: start block 15:0, end block 31:16, 4KB units
   localparam int UCS_WIN_START_LSB = 0;
   localparam int UCS_WIN_END_LSB = 16;
   localparam logic [31:0] UCS_WIN_RST = 32'h0000_0000;

   // internal memory region, selected by address bits 31:16
   localparam logic [15:0] UCS_INT_REGION = 16'h1000;
   // area within it, address bits 14:13
   localparam logic [1:0] UCS_AREA_DATA = 2'h0;
   localparam logic [1:0] UCS_AREA_TAG = 2'h1;
   localparam logic [1:0] UCS_AREA_LRU = 2'h2;

   localparam logic [6:0] UCS_LAST_LINE = 7'h7F;
   localparam logic [1:0] UCS_LAST_WORD = 2'h3;
   localparam logic [31:0] UCS_WORD_STEP = 32'h0000_0004;

   // way-state codes along the fill sequence from empty
   localparam logic [3:0] UCS_WS_EMPTY = 4'h0;
   localparam logic [3:0] UCS_WS_ONE = 4'h6;
   localparam logic [3:0] UCS_WS_TWO = 4'h3;
   localparam logic [3:0] UCS_WS_THREE = 4'h5;
   localparam logic [3:0] UCS_WS_FULL = 4'h8;

   typedef enum logic [2:0] {
      UCS_INIT = 3'b000,
      UCS_IDLE = 3'b001,
      UCS_DONE = 3'b010,
      UCS_MEMRD = 3'b011,
      UCS_MEMWR = 3'b100,
      UCS_FILL = 3'b101
   } ucs_state_t;

endpackage
`default_nettype wire

// ### design/ucs_window_check.sv
`timescale 1ns/1ps
`default_nettype none
module ucs_window_check
   import ucs_pkg::*;
(
   input wire logic [15:0] block,
   input wire logic [31:0] bounds,
   output logic inWindow
);

   logic [15:0] startBlk;
   logic [15:0] endBlk;

   always_comb
   begin
      startBlk = bounds[UCS_WIN_START_LSB +: 16];
      endBlk = bounds[UCS_WIN_END_LSB +: 16];
      // end names the first block past the window, so it is excluded
      inWindow = (block >= startBlk) && (block < endBlk);
   end

endmodule
`default_nettype wire

// ### design/ucs_way_state.sv
`timescale 1ns/1ps
`default_nettype none
module ucs_way_state
   import ucs_pkg::*;
(
   input wire logic [3:0] state,
   input wire logic half,
   input wire logic [1:0] usedWay,
   output logic [3:0] valid,
   output logic [1:0] victim,
   output logic [3:0] nextState
);

   always_comb
   begin
      valid = 4'h0;
      if (half)
      begin
         // two-way use: way 1 valid while bits 2:1 read 10 or bit 3 is set
         valid[0] = (state != UCS_WS_EMPTY);
         valid[1] = state[3] | (state[2] & ~state[1]);
      end
      else if (state[3])
         valid = 4'hF;
      else
      begin
         unique case (state)
            UCS_WS_ONE: valid = 4'h1;
            UCS_WS_TWO: valid = 4'h5;
            UCS_WS_THREE: valid = 4'h7;
            default: valid = 4'h0;
         endcase
      end
      // bit 2 picks the group, bit 1 the way in group 0, bit 0 in group 1
      if (half)
         victim = {1'b0, state[1]};
      else if (state[2])
         victim = {1'b1, state[0]};
      else
         victim = {1'b0, state[1]};
      // point the tree away from the way just used; this rule also walks an
      // empty line through 0110, 0011 and 0101, and the step to 1000 is forced below
      nextState = state;
      unique case (usedWay)
         2'h0: nextState[2:1] = 2'h3;
         2'h1: nextState[2:1] = 2'h2;
         2'h2: {nextState[2], nextState[0]} = 2'h1;
         2'h3: {nextState[2], nextState[0]} = 2'h0;
      endcase
      if (!half && (state == UCS_WS_THREE) && (usedWay == 2'h3))
         nextState = UCS_WS_FULL;
   end

endmodule
`default_nettype wire

// ### design/ucs_cache_top.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 8KB internal memory serves as full cache, half cache plus SRAM, or all SRAM.
// - four ways, 16-byte lines of four words, four tag arrays, one way-state array.
// - every core write outside the internal memory region also goes out to external memory.
// - a cacheable read miss fetches four words in ascending address order.
// - after initialization all way-state entries read 0000, nothing valid.
// - in full cache mode, fills from empty step way-state 0110, 0011, 0101, then 1000.
// - with top bit set, the low three bits choose the victim.
// - bit 2 picks group, bit 1 way 0 or 1, bit 0 way 2 or 3.
// - mode field 01 or 11 enables caching, 00 disables it.
// - while disabled, reads go to external memory and the cache is untouched.
// - re-enabling the cache never flushes it by itself.
// - while disabled, software reads and writes the way-state array freely.
// - writing zero into way-state entries invalidates those lines.
// - two uncached windows, each with its own start and end field.
// - reads inside a window go external without touching any line.
// - windows count in 4KB blocks; the end block lies outside.
// - half mode gives ways 2 and 3 to SRAM, ways 0 and 1 cache.
// - internal SRAM answers in one clock cycle.
// - mode 10 is reserved; 11 selects full 8KB cache.
module ucs_cache_top
   import ucs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic coreReq,
   input wire logic coreWe,
   input wire logic [31:0] coreAddr,
   input wire logic [31:0] coreWdata,
   output logic [31:0] coreRdata,
   output logic coreReady,
   output logic memReq,
   output logic memWe,
   output logic [31:0] memAddr,
   output logic [31:0] memWdata,
   input wire logic [31:0] memRdata,
   input wire logic memAck
);

   logic [31:0] dataMem [0:2047];
   logic [20:0] tagMem [0:511];
   logic [3:0] lruMem [0:127];

   logic [7:0] sysConfig, next_sysConfig;
   logic [31:0] win0, next_win0, win1, next_win1;
   logic [31:0] next_regRdata;
   ucs_state_t state, next_state;
   logic [6:0] initIdx, next_initIdx;
   logic [1:0] fillCnt, next_fillCnt;
   logic [1:0] fillWay, next_fillWay;
   logic next_memReq, next_memWe, next_coreReady;
   logic [31:0] next_memAddr, next_memWdata, next_coreRdata;

   logic [1:0] mode;
   logic cacheOn, half, internal, inWin0, inWin1, cacheable;
   logic [6:0] lineIdx;
   logic [3:0] wsState, wsValid, wsNext;
   logic [1:0] victim, usedWay, hitWay, expVictim;
   logic hitAny, startFill, lruUpd;
   logic dataWe, tagWe, lruWe;
   logic [10:0] dataWaddr;
   logic [8:0] tagWaddr;
   logic [6:0] lruWaddr;
   logic [31:0] dataWdata;
   logic [20:0] tagWdata;
   logic [3:0] lruWdata;

   // register port
   always_comb
   begin
      next_sysConfig = sysConfig;
      next_win0 = win0;
      next_win1 = win1;
      next_regRdata = 32'h0000_0000;
      // a mode change leaves the arrays alone; stale lines stay until flushed
      if (regWr)
      begin
         unique case (regAddr)
            UCS_OFS_SYS_CONFIG: next_sysConfig = regWdata[7:0] & UCS_SYS_CONFIG_MASK;
            UCS_OFS_WIN0: next_win0 = regWdata;
            UCS_OFS_WIN1: next_win1 = regWdata;
            default: next_sysConfig = sysConfig;
         endcase
      end
      if (regRd)
      begin
         unique case (regAddr)
            UCS_OFS_SYS_CONFIG: next_regRdata = {24'h00_0000, sysConfig};
            UCS_OFS_WIN0: next_regRdata = win0;
            UCS_OFS_WIN1: next_regRdata = win1;
            default: next_regRdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sysConfig <= UCS_SYS_CONFIG_RST;
         win0 <= UCS_WIN_RST;
         win1 <= UCS_WIN_RST;
         regRdata <= 32'h0000_0000;
      end
      else
      begin
         sysConfig <= next_sysConfig;
         win0 <= next_win0;
         win1 <= next_win1;
         regRdata <= next_regRdata;
      end
   end

   // reserved mode 10 behaves like 00
   assign mode = sysConfig[UCS_MODE_LSB +: 2];
   assign cacheOn = (mode == UCS_MODE_HALF) || (mode == UCS_MODE_FULL);
   assign half = (mode == UCS_MODE_HALF);
   assign internal = (coreAddr[31:16] == UCS_INT_REGION);
   assign lineIdx = coreAddr[10:4];
   assign wsState = lruMem[lineIdx];
   assign cacheable = cacheOn && !inWin0 && !inWin1;
   assign usedWay = (state == UCS_FILL) ? fillWay : hitWay;
   assign expVictim = wsState[2] ? {1'b1, wsState[0]} : {1'b0, wsState[1]};

   ucs_window_check u_win0 (
      .block(coreAddr[27:12]),
      .bounds(win0),
      .inWindow(inWin0)
   );

   ucs_window_check u_win1 (
      .block(coreAddr[27:12]),
      .bounds(win1),
      .inWindow(inWin1)
   );

   ucs_way_state u_ways (
      .state(wsState),
      .half(half),
      .usedWay(usedWay),
      .valid(wsValid),
      .victim(victim),
      .nextState(wsNext)
   );

   // all ways compared in the same cycle
   always_comb
   begin
      hitAny = 1'b0;
      hitWay = 2'h0;
      for (int w = 0; w < 4; w++)
      begin
         if (cacheOn && wsValid[w] && (tagMem[{w[1:0], lineIdx}] == coreAddr[31:11]))
         begin
            hitAny = 1'b1;
            hitWay = w[1:0];
         end
      end
   end

   // control
   always_comb
   begin
      next_state = state;
      next_initIdx = initIdx;
      next_fillCnt = fillCnt;
      next_fillWay = fillWay;
      next_memReq = memReq;
      next_memWe = memWe;
      next_memAddr = memAddr;
      next_memWdata = memWdata;
      next_coreRdata = coreRdata;
      next_coreReady = 1'b0;
      startFill = 1'b0;
      lruUpd = 1'b0;
      dataWe = 1'b0;
      tagWe = 1'b0;
      lruWe = 1'b0;
      dataWaddr = coreAddr[12:2];
      dataWdata = coreWdata;
      tagWaddr = coreAddr[12:4];
      tagWdata = coreWdata[31:11];
      lruWaddr = lineIdx;
      lruWdata = coreWdata[3:0];
      unique case (state)
         UCS_INIT:
         begin
            lruWe = 1'b1;
            lruWaddr = initIdx;
            lruWdata = UCS_WS_EMPTY;
            next_initIdx = initIdx + 7'h01;
            if (initIdx == UCS_LAST_LINE)
               next_state = UCS_IDLE;
         end
         UCS_IDLE:
         begin
            if (coreReq && internal)
            begin
               next_state = UCS_DONE;
               next_coreReady = 1'b1;
               next_coreRdata = 32'h0000_0000;
               unique case (coreAddr[14:13])
                  UCS_AREA_DATA:
                  begin
                     if (!cacheOn || (half && coreAddr[12]))
                     begin
                        dataWe = coreWe;
                        next_coreRdata = dataMem[coreAddr[12:2]];
                     end
                  end
                  UCS_AREA_TAG:
                  begin
                     if (!cacheOn)
                     begin
                        tagWe = coreWe;
                        next_coreRdata = {tagMem[coreAddr[12:4]], 11'h000};
                     end
                  end
                  UCS_AREA_LRU:
                  begin
                     // zero written here invalidates the line in every way
                     if (!cacheOn && !coreAddr[12] && !coreAddr[11])
                     begin
                        lruWe = coreWe;
                        next_coreRdata = {28'h000_0000, wsState};
                     end
                  end
                  default: next_coreRdata = 32'h0000_0000;
               endcase
            end
            else if (coreReq && coreWe)
            begin
               next_state = UCS_MEMWR;
               next_memReq = 1'b1;
               next_memWe = 1'b1;
               next_memAddr = coreAddr;
               next_memWdata = coreWdata;
               // hit updates the word; a miss allocates nothing
               if (hitAny)
               begin
                  dataWe = 1'b1;
                  dataWaddr = {hitWay, lineIdx, coreAddr[3:2]};
               end
            end
            else if (coreReq && cacheable && hitAny)
            begin
               next_state = UCS_DONE;
               next_coreReady = 1'b1;
               next_coreRdata = dataMem[{hitWay, lineIdx, coreAddr[3:2]}];
               lruUpd = 1'b1;
               lruWe = 1'b1;
               lruWdata = wsNext;
            end
            else if (coreReq && cacheable)
            begin
               startFill = 1'b1;
               next_state = UCS_FILL;
               next_fillWay = victim;
               next_fillCnt = 2'h0;
               next_memReq = 1'b1;
               next_memWe = 1'b0;
               next_memAddr = {coreAddr[31:4], 4'h0};
            end
            else if (coreReq)
            begin
               next_state = UCS_MEMRD;
               next_memReq = 1'b1;
               next_memWe = 1'b0;
               next_memAddr = coreAddr;
            end
         end
         UCS_MEMRD, UCS_MEMWR:
         begin
            if (memAck)
            begin
               next_memReq = 1'b0;
               next_memWe = 1'b0;
               next_coreReady = 1'b1;
               if (state == UCS_MEMRD)
                  next_coreRdata = memRdata;
               next_state = UCS_DONE;
            end
         end
         UCS_FILL:
         begin
            if (memAck)
            begin
               dataWe = 1'b1;
               dataWaddr = {fillWay, lineIdx, fillCnt};
               dataWdata = memRdata;
               if (fillCnt == coreAddr[3:2])
                  next_coreRdata = memRdata;
               if (fillCnt == UCS_LAST_WORD)
               begin
                  next_memReq = 1'b0;
                  next_coreReady = 1'b1;
                  next_state = UCS_DONE;
                  tagWe = 1'b1;
                  tagWaddr = {fillWay, lineIdx};
                  tagWdata = coreAddr[31:11];
                  lruUpd = 1'b1;
                  lruWe = 1'b1;
                  lruWdata = wsNext;
               end
               else
               begin
                  next_fillCnt = fillCnt + 2'h1;
                  next_memAddr = memAddr + UCS_WORD_STEP;
               end
            end
         end
         UCS_DONE: next_state = UCS_IDLE;
         default: next_state = UCS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= UCS_INIT;
         initIdx <= 7'h00;
         fillCnt <= 2'h0;
         fillWay <= 2'h0;
         memReq <= 1'b0;
         memWe <= 1'b0;
         memAddr <= 32'h0000_0000;
         memWdata <= 32'h0000_0000;
         coreRdata <= 32'h0000_0000;
         coreReady <= 1'b0;
      end
      else
      begin
         state <= next_state;
         initIdx <= next_initIdx;
         fillCnt <= next_fillCnt;
         fillWay <= next_fillWay;
         memReq <= next_memReq;
         memWe <= next_memWe;
         memAddr <= next_memAddr;
         memWdata <= next_memWdata;
         coreRdata <= next_coreRdata;
         coreReady <= next_coreReady;
      end
   end

   // arrays hold no reset; the way-state array is cleared by the init walk
   always_ff @(posedge clk)
   begin
      if (dataWe)
         dataMem[dataWaddr] <= dataWdata;
      if (tagWe)
         tagMem[tagWaddr] <= tagWdata;
      if (lruWe)
         lruMem[lruWaddr] <= lruWdata;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_init_clear: assert property (state == UCS_INIT |-> lruWe && lruWdata == UCS_WS_EMPTY)
      else $error("init walk does not clear way-state");
   a_write_through: assert property (state == UCS_IDLE && coreReq && coreWe && !internal
      |=> memReq && memWe && memAddr == $past(coreAddr) && memWdata == $past(coreWdata))
      else $error("core write not sent to external memory");
   a_fill_order: assert property (state == UCS_FILL && memAck && fillCnt != UCS_LAST_WORD
      |=> memReq && memAddr == $past(memAddr) + UCS_WORD_STEP)
      else $error("fill address not sequential");
   a_fill_ends: assert property (state == UCS_FILL && memAck && fillCnt == UCS_LAST_WORD
      |=> coreReady && !memReq ##1 !coreReady)
      else $error("fill does not end after fourth word");
   a_fill_steps: assert property (lruUpd && state == UCS_FILL && !half && wsState == UCS_WS_EMPTY
      |-> lruWdata == UCS_WS_ONE)
      else $error("first fill does not give 0110");
   a_victim_pick: assert property (startFill && !half && wsState[3] |=> fillWay == $past(expVictim))
      else $error("victim not taken from low way-state bits");
   a_off_untouched: assert property (state == UCS_IDLE && !cacheOn |-> !startFill && !lruUpd)
      else $error("cache used while disabled");
   a_window_bypass: assert property (state == UCS_IDLE && coreReq && !coreWe && !internal
      && (inWin0 || inWin1) |=> state == UCS_MEMRD)
      else $error("windowed read allocated");
   a_hit_noext: assert property (state == UCS_IDLE && coreReq && !coreWe && !internal
      && cacheable && hitAny |=> coreReady && !memReq)
      else $error("hit went to external memory");
   a_sram_cycle: assert property (state == UCS_IDLE && coreReq && internal |=> coreReady ##1 !coreReady)
      else $error("internal access not one cycle");
   a_half_ways: assert property (startFill && half |-> victim[1] == 1'b0)
      else $error("half mode filled an SRAM way");
   a_write_noalloc: assert property (state == UCS_IDLE && coreReq && coreWe && !internal
      |-> !tagWe && !lruWe && !startFill ##1 state == UCS_MEMWR)
      else $error("write allocated a line");

   c_hit: cover property (state == UCS_IDLE && coreReq && !coreWe && cacheable && hitAny && !internal);
   c_fill_full: cover property (lruUpd && state == UCS_FILL && wsState == UCS_WS_THREE && !half);
   c_window_read: cover property (state == UCS_MEMRD && memAck && (inWin0 || inWin1));
   c_flush_write: cover property (lruWe && state == UCS_IDLE && lruWdata == UCS_WS_EMPTY);

endmodule
`default_nettype wire

// ### sim/ucs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucs_mem_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [31:0] memAddr,
   input wire logic [31:0] memWdata,
   input wire logic [3:0] lat,
   output logic [31:0] memRdata,
   output logic memAck
);
   logic [31:0] store [logic [31:0]];
   logic [31:0] rdLog [$];
   logic [31:0] lastWrAddr;
   logic [31:0] lastWrData;
   int wrCount;
   int waitCnt;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         memAck <= 1'b0;
         memRdata <= 32'h0;
         waitCnt <= 0;
         wrCount = 0;
      end
      else if (memReq && !memAck && waitCnt >= lat)
      begin
         memAck <= 1'b1;
         waitCnt <= 0;
         if (memWe)
         begin
            store[memAddr] = memWdata;
            lastWrAddr = memAddr;
            lastWrData = memWdata;
            wrCount++;
         end
         else
         begin
            rdLog.push_back(memAddr);
            memRdata <= store.exists(memAddr) ? store[memAddr] : {memAddr[15:0], ~memAddr[15:0]};
         end
      end
      else
      begin
         // no stale data between acks: the bus floats, so it toggles here
         memAck <= 1'b0;
         memRdata <= ~memRdata;
         if (memReq && !memAck)
            waitCnt <= waitCnt + 1;
      end
   end
endmodule
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import ucs_pkg::*;
;
   logic clk;
   logic rst;
   logic [3:0] regAddr;
   logic [31:0] regWdata;
   logic regWr;
   logic regRd;
   logic [31:0] regRdata;
   logic coreReq;
   logic coreWe;
   logic [31:0] coreAddr;
   logic [31:0] coreWdata;
   logic [31:0] coreRdata;
   logic coreReady;
   logic memReq;
   logic memWe;
   logic [31:0] memAddr;
   logic [31:0] memWdata;
   logic [31:0] memRdata;
   logic memAck;
   logic [3:0] lat;
   int nErrors = 0;
   int comparisons = 0;
   int seed;

   ucs_cache_top dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .coreReq(coreReq), .coreWe(coreWe), .coreAddr(coreAddr),
      .coreWdata(coreWdata), .coreRdata(coreRdata), .coreReady(coreReady), .memReq(memReq), .memWe(memWe),
      .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));
   ucs_mem_model memModel (.clk(clk), .rst(rst), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
      .memWdata(memWdata), .lat(lat), .memRdata(memRdata), .memAck(memAck));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic finalReport();
      $display("comparisons %0d mismatches %0d", comparisons, nErrors);
      if (nErrors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         nErrors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [31:0] em(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction

   function automatic logic [31:0] ws(input logic [6:0] i);
      return 32'h1000_4000 | {21'h0, i, 4'h0};
   endfunction

   function automatic int vic(input logic [2:0] b);
      return b[2] ? 2 + b[0] : b[1];
   endfunction

   task automatic regW(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic regR(input logic [3:0] a, output logic [31:0] q);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
      q = regRdata;
   endtask

   task automatic setMode(input logic [1:0] m);
      regW(UCS_OFS_SYS_CONFIG, {29'h0, m, 1'b0});
   endtask

   task automatic op(input logic we, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q,
      output int n);
      @(posedge clk);
      coreReq <= 1'b1;
      coreWe <= we;
      coreAddr <= a;
      coreWdata <= d;
      for (n = 1; n <= 300; n++)
      begin
         @(posedge clk);
         if (coreReady === 1'b1)
            break;
      end
      q = coreRdata;
      coreReq <= 1'b0;
      if (n > 300)
      begin
         nErrors++;
         $display("[ERR] coreReady expected 1 seen timeout");
         finalReport();
      end
   endtask

   // eLat and eExt below zero mean do not care
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input int eLat, input int eExt);
      logic [31:0] q;
      int n;
      int k;
      k = memModel.rdLog.size();
      op(1'b0, a, 32'h0, q, n);
      check("coreRdata", q, e);
      if (eLat > 0)
         check("latency", 32'(n), 32'(eLat));
      if (eExt >= 0)
         check("extReads", 32'(memModel.rdLog.size() - k), 32'(eExt));
      if (eExt == 4)
         for (int i = 0; i < 4; i++)
            check("fillAddr", memModel.rdLog[k + i], {a[31:4], 4'h0} + 32'(i * 4));
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d, input int eExt);
      logic [31:0] q;
      int n;
      int k;
      k = memModel.wrCount;
      op(1'b1, a, d, q, n);
      check("extWrites", 32'(memModel.wrCount - k), 32'(eExt));
      if (eExt == 1)
      begin
         check("memAddr", memModel.lastWrAddr, a);
         check("memWdata", memModel.lastWrData, d);
      end
   endtask

   initial
   begin
      logic [31:0] q;
      logic [31:0] a;
      logic [3:0] seq [4];
      logic [31:0] wa [5];
      int we [5];
      seq = '{4'h6, 4'h3, 4'h5, 4'h8};
      wa = '{32'h0001_0000, 32'h0002_2FF0, 32'h0002_3000, 32'h0000_FFF0, 32'h0004_0A40};
      we = '{1, 1, 4, 4, 1};
      seed = 32'hD2F413ED;
      rst = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 4'h0;
      regWdata = 32'h0;
      coreReq = 1'b0;
      coreWe = 1'b0;
      coreAddr = 32'h0;
      coreWdata = 32'h0;
      lat = 4'h2;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      regR(UCS_OFS_SYS_CONFIG, q);
      check("sysConfig", q, 32'h0000_0001);
      regR(UCS_OFS_WIN1, q);
      check("window1", q, 32'h0);
      regR(4'hC, q);
      check("unmapped", q, 32'h0);
      regW(UCS_OFS_SYS_CONFIG, 32'h0000_00FF);
      regR(UCS_OFS_SYS_CONFIG, q);
      check("sysConfig", q, 32'h0000_003F);
      setMode(UCS_MODE_OFF);
      rd(ws(7'h00), 32'h0, -1, 0);
      rd(ws(7'h7F), 32'h0, 2, 0);
      wr(32'h1000_1F04, 32'h5A5A_0001, 0);
      rd(32'h1000_1F04, 32'h5A5A_0001, 2, 0);
      foreach (seq[m])
      begin
         setMode(m[0] ? UCS_MODE_RSVD : UCS_MODE_OFF);
         rd(32'h0003_0010, em(32'h0003_0010), -1, 1);
      end
      for (int k = 0; k < 4; k++)
      begin
         a = 32'h0004_0218 + 32'(k << 11);
         setMode(UCS_MODE_FULL);
         rd(a, em(a), -1, 4);
         setMode(UCS_MODE_OFF);
         rd(ws(7'h21), 32'(seq[k]), -1, 0);
      end
      setMode(UCS_MODE_FULL);
      rd(32'h0004_0218, em(32'h0004_0218), 2, 0);
      for (int b = 0; b < 8; b++)
      begin
         a = 32'h0008_0210 + 32'(b << 11);
         setMode(UCS_MODE_OFF);
         wr(ws(7'h21), 32'(8 + b), 0);
         setMode(UCS_MODE_FULL);
         rd(a, em(a), -1, 4);
         setMode(UCS_MODE_OFF);
         rd(32'h1000_2210 + 32'(vic(3'(b)) * 32'h800), {a[31:11], 11'h0}, -1, 0);
      end
      setMode(UCS_MODE_FULL);
      wr(a, 32'hCAFE_0001, 1);
      rd(a, 32'hCAFE_0001, 2, 0);
      wr(32'h0007_0040, 32'hCAFE_0002, 1);
      rd(32'h0007_0040, 32'hCAFE_0002, -1, 4);
      setMode(UCS_MODE_OFF);
      wr(ws(7'h21), 32'h0, 0);
      setMode(UCS_MODE_FULL);
      rd(a, 32'hCAFE_0001, -1, 4);
      regW(UCS_OFS_WIN0, 32'h0023_0010);
      regW(UCS_OFS_WIN1, 32'h0041_0040);
      foreach (wa[i])
      begin
         rd(wa[i], em(wa[i]), -1, we[i]);
         rd(wa[i], em(wa[i]), -1, we[i] == 4 ? 0 : 1);
      end
      setMode(UCS_MODE_HALF);
      wr(32'h1000_1800, 32'h1234_5678, 0);
      rd(32'h1000_1800, 32'h1234_5678, 2, 0);
      rd(32'h1000_0800, 32'h0, 2, 0);
      rd(32'h0005_0100, em(32'h0005_0100), -1, 4);
      rd(32'h0005_0100, em(32'h0005_0100), 2, 0);
      setMode(UCS_MODE_FULL);
      repeat (40)
      begin
         a = 32'h0006_0000 | (32'($random(seed)) & 32'h0000_0FFC);
         lat <= 4'($random(seed) & 7);
         rd(a, em(a), -1, -1);
      end
      finalReport();
   end
endmodule
`default_nettype wire
